/* src/acc_pkg.sv */
package acc_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [2:0] ADDR_CONTROL_A = 3'h0;
   localparam logic [2:0] ADDR_CONTROL_B = 3'h1;
   localparam logic [2:0] ADDR_INPUT_SELECT = 3'h2;
   localparam logic [2:0] ADDR_RESULT_LOW = 3'h3;
   localparam logic [2:0] ADDR_RESULT_HIGH = 3'h4;

   // ---------------------------------------------------------------
   // converter_control_a fields
   // ---------------------------------------------------------------
   localparam int CA_ENABLE_BIT = 7;
   localparam int CA_START_BIT = 6;
   localparam int CA_AUTO_BIT = 5;
   localparam int CA_FLAG_BIT = 4;
   localparam int CA_PRESCALE_LSB = 0;
   localparam int PRESCALE_WIDTH = 3;

   // ---------------------------------------------------------------
   // converter_control_b and input_select_register fields
   // ---------------------------------------------------------------
   localparam int CB_TRIGGER_LSB = 0;
   localparam int TRIGGER_SELECT_WIDTH = 3;
   localparam int IS_CHANNEL_LSB = 0;
   localparam int CHANNEL_WIDTH = 5;
   localparam int IS_ALIGN_BIT = 5;
   localparam int IS_REFERENCE_LSB = 6;
   localparam int REFERENCE_WIDTH = 2;

   // ---------------------------------------------------------------
   // trigger sources and reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] TRIGGER_FREE_RUN = 3'h0;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [2:0] RESET_PRESCALE = 3'h0;
   localparam logic [2:0] RESET_TRIGGER = 3'h0;
   localparam logic [4:0] RESET_CHANNEL = 5'h00;
   localparam logic [1:0] RESET_REFERENCE = 2'h0;

   // ---------------------------------------------------------------
   // conversion figures; the cycle counts are in converter clock cycles
   // ---------------------------------------------------------------
   localparam int RESULT_BITS = 10;
   localparam int NORMAL_CYCLES = 13;
   localparam int FIRST_CYCLES = 25;
   localparam int PRESCALE_COUNT_WIDTH = 7;

endpackage : acc_pkg

/* src/acc_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none
module acc_prescaler #(
   parameter int COUNT_WIDTH = acc_pkg::PRESCALE_COUNT_WIDTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic run,
   input wire logic restart,
   input wire logic [acc_pkg::PRESCALE_WIDTH-1:0] select,
   // converter clock enable
   output logic tick
);

   // ---------------------------------------------------------------
   // divider
   // ---------------------------------------------------------------
   // select 0 divides by two like select 1: the converter never runs at cpu rate
   function automatic logic [COUNT_WIDTH-1:0] last_count(
      input logic [acc_pkg::PRESCALE_WIDTH-1:0] sel);
      logic [COUNT_WIDTH:0] span;
      span = '0;
      span[(sel == '0) ? 1 : int'(sel)] = 1'b1;
      return COUNT_WIDTH'(span - 1'b1);
   endfunction : last_count

   logic [COUNT_WIDTH-1:0] count;

   always_ff @(posedge clk)
   begin
      if (reset || !run || restart)
      begin
         count <= '0; // R19 R9
      end
      else if (count >= last_count(select))
      begin
         count <= '0;
      end
      else
      begin
         count <= count + 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset || !run || restart)
      begin
         tick <= 1'b0;
      end
      else
      begin
         tick <= (count >= last_count(select));
      end
   end

endmodule : acc_prescaler
`default_nettype wire

/* src/acc_sar.sv */
`timescale 1ns/1ns
`default_nettype none
module acc_sar #(
   parameter int BITS = acc_pkg::RESULT_BITS,
   parameter int NORMAL = acc_pkg::NORMAL_CYCLES,
   parameter int FIRST = acc_pkg::FIRST_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic enable,
   input wire logic tick,
   input wire logic go,
   input wire logic first,
   // analog side
   input wire logic comparator_high,
   output logic [BITS-1:0] dac_code,
   output logic sample_hold,
   // status
   output logic busy,
   output logic done,
   output logic [BITS-1:0] result
);

   typedef enum logic [1:0] {idle, sampling, approximating, completing} acc_sar_state_type;

   acc_sar_state_type state;
   logic [4:0] count;
   logic [4:0] settle_last;
   logic [3:0] bit_index;
   logic [BITS-1:0] code;
   logic [BITS-1:0] next_code;

   // sampling ticks = total - bits - 1, so the total comes out as 13 or 25
   assign next_code = comparator_high ? dac_code : code; // R1
   assign busy = (state != idle);
   assign sample_hold = (state == sampling);

   always_ff @(posedge clk)
   begin
      if (reset || !enable)
      begin
         state <= idle;
         count <= '0;
         settle_last <= '0;
         bit_index <= '0;
         code <= '0;
         dac_code <= '0;
      end
      else
      begin
         unique case (state)
            idle:
            begin
               if (go)
               begin
                  state <= sampling;
                  count <= '0;
                  settle_last <= first ? 5'(FIRST - BITS - 2) : 5'(NORMAL - BITS - 2); // R17
                  bit_index <= 4'(BITS - 1);
                  code <= '0;
                  dac_code <= '0;
                  dac_code[BITS-1] <= 1'b1;
               end
            end
            sampling:
            begin
               if (tick)
               begin
                  count <= count + 1'b1;
                  if (count == settle_last)
                  begin
                     state <= approximating;
                  end
               end
            end
            approximating:
            begin
               if (tick)
               begin
                  code <= next_code; // R1
                  dac_code <= next_code;
                  if (bit_index == '0)
                  begin
                     state <= completing;
                  end
                  else
                  begin
                     dac_code[bit_index-1'b1] <= 1'b1;
                     bit_index <= bit_index - 1'b1;
                  end
               end
            end
            completing:
            begin
               if (tick)
               begin
                  state <= idle;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset || !enable)
      begin
         done <= 1'b0;
         result <= '0;
      end
      else
      begin
         done <= (state == completing) && tick;
         if ((state == completing) && tick)
         begin
            result <= code;
         end
      end
   end

endmodule : acc_sar
`default_nettype wire

/* src/acc_adc_conversion_control.sv */
// Function
// R1: successive approximation gives ten-bit code
// R2: selections apply only while converter enabled
// R3: right adjusted, left when align set
// R4: low byte read locks result bytes
// R5: high byte read unlocks result bytes
// R6: completion flag set even when discarded
// R7: start bit high until conversion completes
// R8: channel change waits for running conversion
// R9: trigger edge restarts prescaler, starts conversion
// R10: held trigger level never restarts conversion
// R11: trigger edges during conversion are ignored
// R12: trigger flag must fall before retrigger
// R13: free running restarts on every completion
// R14: software starts first free running conversion
// R15: software start works with auto trigger
// R16: start bit reads one while converting
// R17: thirteen cycles, twenty-five for first
// R18: completion writes result, flag, clears start
// R19: prescaler held reset while disabled
// R20: trigger edge from per-clock sample compare
`timescale 1ns/1ns
`default_nettype none
module acc_adc_conversion_control #(
   parameter int TRIGGER_COUNT = 7,
   parameter int BITS = acc_pkg::RESULT_BITS
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // trigger sources, code n selects bit n-1
   input wire logic [TRIGGER_COUNT-1:0] trigger_sources,
   // analog side
   input wire logic comparator_high,
   output logic [BITS-1:0] dac_code,
   output logic sample_hold,
   output logic [acc_pkg::CHANNEL_WIDTH-1:0] channel_select_bits,
   output logic [acc_pkg::REFERENCE_WIDTH-1:0] reference_select_bits,
   output logic converter_powered
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] result_byte(input logic [BITS-1:0] value,
      input logic left, input logic high);
      logic [15:0] placed;
      placed = left ? {value, 6'h00} : {6'h00, value};
      return high ? placed[15:8] : placed[7:0];
   endfunction : result_byte

   function automatic logic pick_trigger(input logic [TRIGGER_COUNT-1:0] sources,
      input logic [acc_pkg::TRIGGER_SELECT_WIDTH-1:0] sel);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < TRIGGER_COUNT; i++)
      begin
         if (int'(sel) == i + 1)
         begin
            hit = sources[i];
         end
      end
      return hit;
   endfunction : pick_trigger

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic converter_enable;
   logic auto_trigger_enable;
   logic conversion_complete_flag;
   logic [acc_pkg::PRESCALE_WIDTH-1:0] prescaler_select;
   logic [acc_pkg::TRIGGER_SELECT_WIDTH-1:0] trigger_source_select;
   logic [acc_pkg::CHANNEL_WIDTH-1:0] channel_written;
   logic [acc_pkg::REFERENCE_WIDTH-1:0] reference_written;
   logic result_left_align;
   logic start_pending;
   logic first_conversion;
   logic [BITS-1:0] result;
   logic result_lock;
   logic trigger_prev;

   logic write_a;
   logic write_b;
   logic write_select;
   logic read_low;
   logic read_high;
   logic enable_written;
   logic software_start;
   logic trigger_now;
   logic trigger_edge;
   logic free_run_start;
   logic conversion_active;
   logic conversion_start;
   logic go;
   logic tick;
   logic sar_busy;
   logic sar_done;
   logic [BITS-1:0] sar_result;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   assign write_a = reg_write && (reg_addr == acc_pkg::ADDR_CONTROL_A);
   assign write_b = reg_write && (reg_addr == acc_pkg::ADDR_CONTROL_B);
   assign write_select = reg_write && (reg_addr == acc_pkg::ADDR_INPUT_SELECT);
   assign read_low = reg_read && (reg_addr == acc_pkg::ADDR_RESULT_LOW);
   assign read_high = reg_read && (reg_addr == acc_pkg::ADDR_RESULT_HIGH);
   assign enable_written = reg_wdata[acc_pkg::CA_ENABLE_BIT];

   // ---------------------------------------------------------------
   // start sources
   // ---------------------------------------------------------------
   // done cycle still counts, so start falls with the flag rise
   assign conversion_active = start_pending || sar_busy || sar_done; // R18
   assign conversion_start = conversion_active; // R16 R7
   assign software_start = write_a && enable_written && reg_wdata[acc_pkg::CA_START_BIT]; // R15 R14
   assign trigger_now = pick_trigger(trigger_sources, trigger_source_select);
   // only a fresh rise counts, so a flag left set blocks the next trigger
   assign trigger_edge = converter_enable && auto_trigger_enable &&
      (trigger_source_select != acc_pkg::TRIGGER_FREE_RUN) &&
      trigger_now && !trigger_prev && !conversion_active; // R10 R11 R12 R9
   // own completion restarts regardless of the flag state
   assign free_run_start = converter_enable && auto_trigger_enable &&
      (trigger_source_select == acc_pkg::TRIGGER_FREE_RUN) && sar_done; // R13
   assign go = start_pending && tick && !sar_busy;
   assign converter_powered = converter_enable;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         trigger_prev <= 1'b0;
      end
      else
      begin
         trigger_prev <= trigger_now; // R20
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         converter_enable <= 1'b0;
         auto_trigger_enable <= 1'b0;
         prescaler_select <= acc_pkg::RESET_PRESCALE;
      end
      else if (write_a)
      begin
         converter_enable <= enable_written;
         auto_trigger_enable <= reg_wdata[acc_pkg::CA_AUTO_BIT];
         prescaler_select <= reg_wdata[acc_pkg::CA_PRESCALE_LSB +: acc_pkg::PRESCALE_WIDTH];
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         trigger_source_select <= acc_pkg::RESET_TRIGGER;
      end
      else if (write_b)
      begin
         trigger_source_select <= reg_wdata[acc_pkg::CB_TRIGGER_LSB +:
            acc_pkg::TRIGGER_SELECT_WIDTH];
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         channel_written <= acc_pkg::RESET_CHANNEL;
         reference_written <= acc_pkg::RESET_REFERENCE;
         result_left_align <= 1'b0;
      end
      else if (write_select)
      begin
         channel_written <= reg_wdata[acc_pkg::IS_CHANNEL_LSB +: acc_pkg::CHANNEL_WIDTH];
         reference_written <= reg_wdata[acc_pkg::IS_REFERENCE_LSB +: acc_pkg::REFERENCE_WIDTH];
         result_left_align <= reg_wdata[acc_pkg::IS_ALIGN_BIT];
      end
   end

   // ---------------------------------------------------------------
   // applied selections
   // ---------------------------------------------------------------
   // frozen during a conversion so the sample sees one stable channel
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         channel_select_bits <= acc_pkg::RESET_CHANNEL;
         reference_select_bits <= acc_pkg::RESET_REFERENCE;
      end
      else if (converter_enable && !sar_busy) // R2 R8
      begin
         channel_select_bits <= channel_written;
         reference_select_bits <= reference_written;
      end
   end

   // ---------------------------------------------------------------
   // conversion sequencing
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset || !converter_enable)
      begin
         start_pending <= 1'b0;
      end
      else if (write_a && !enable_written)
      begin
         start_pending <= 1'b0;
      end
      else if (software_start || trigger_edge || free_run_start)
      begin
         start_pending <= 1'b1; // R15 R9 R13
      end
      else if (go)
      begin
         start_pending <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         first_conversion <= 1'b0;
      end
      else if (write_a && enable_written && !converter_enable)
      begin
         first_conversion <= 1'b1; // R17
      end
      else if (go)
      begin
         first_conversion <= 1'b0;
      end
   end

   acc_prescaler #(
      .COUNT_WIDTH(acc_pkg::PRESCALE_COUNT_WIDTH)
   ) prescaler (
      .clk(clk),
      .reset(reset),
      .run(converter_enable), // R19
      .restart(trigger_edge), // R9
      .select(prescaler_select),
      .tick(tick)
   );

   acc_sar #(
      .BITS(BITS),
      .NORMAL(acc_pkg::NORMAL_CYCLES),
      .FIRST(acc_pkg::FIRST_CYCLES)
   ) sar (
      .clk(clk),
      .reset(reset),
      .enable(converter_enable),
      .tick(tick),
      .go(go),
      .first(first_conversion),
      .comparator_high(comparator_high),
      .dac_code(dac_code),
      .sample_hold(sample_hold),
      .busy(sar_busy),
      .done(sar_done),
      .result(sar_result)
   );

   // ---------------------------------------------------------------
   // result and completion
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         result_lock <= 1'b0;
      end
      else if (read_low)
      begin
         result_lock <= 1'b1; // R4
      end
      else if (read_high)
      begin
         result_lock <= 1'b0; // R5
      end
   end

   // a high byte read in the completion cycle already counts as unlocking
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         result <= '0;
      end
      else if (sar_done && (!result_lock || read_high)) // R4 R18
      begin
         result <= sar_result;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         conversion_complete_flag <= 1'b0;
      end
      else if (sar_done)
      begin
         conversion_complete_flag <= 1'b1; // R6 R18
      end
      else if (write_a && reg_wdata[acc_pkg::CA_FLAG_BIT])
      begin
         conversion_complete_flag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset || !reg_read)
      begin
         reg_rdata <= acc_pkg::RESET_BYTE;
      end
      else
      begin
         unique case (reg_addr)
            acc_pkg::ADDR_CONTROL_A:
               reg_rdata <= {converter_enable, conversion_start, auto_trigger_enable,
                  conversion_complete_flag, 1'b0, prescaler_select}; // R16
            acc_pkg::ADDR_CONTROL_B:
               reg_rdata <= {5'h00, trigger_source_select};
            acc_pkg::ADDR_INPUT_SELECT:
               reg_rdata <= {reference_written, result_left_align, channel_written};
            acc_pkg::ADDR_RESULT_LOW:
               reg_rdata <= result_byte(result, result_left_align, 1'b0); // R3
            acc_pkg::ADDR_RESULT_HIGH:
               reg_rdata <= result_byte(result, result_left_align, 1'b1); // R3
            default:
               reg_rdata <= acc_pkg::RESET_BYTE;
         endcase
      end
   end

endmodule : acc_adc_conversion_control
`default_nettype wire

/* verif/acc_adc_conversion_control_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module acc_adc_conversion_control_chk #(
   parameter int TRIGGER_COUNT = 7,
   parameter int BITS = acc_pkg::RESULT_BITS
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // trigger and analog side
   input wire logic [TRIGGER_COUNT-1:0] trigger_sources,
   input wire logic comparator_high,
   input wire logic [BITS-1:0] dac_code,
   input wire logic sample_hold,
   input wire logic [acc_pkg::CHANNEL_WIDTH-1:0] channel_select_bits,
   input wire logic [acc_pkg::REFERENCE_WIDTH-1:0] reference_select_bits,
   input wire logic converter_powered
);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   unmapped_read_a: assert property ($past(reg_read) && $past(reg_addr) > 3'h4 |->
      reg_rdata == 8'h00) else $error("unmapped read not zero");
   powered_follow_a: assert property (reg_write && reg_addr == 3'h0 |=>
      converter_powered == $past(reg_wdata[7])) else $error("power does not follow enable");
   chan_off_hold_a: assert property (!converter_powered |=>
      $stable(channel_select_bits)) else $error("channel applied while disabled");
   ref_off_hold_a: assert property (!converter_powered |=>
      $stable(reference_select_bits)) else $error("reference applied while disabled");
   chan_lock_a: assert property (sample_hold && $past(sample_hold) |->
      $stable(channel_select_bits)) else $error("channel moved while sampling");
   ref_lock_a: assert property (sample_hold && $past(sample_hold) |->
      $stable(reference_select_bits)) else $error("reference moved while sampling");
   sample_power_a: assert property (sample_hold |->
      converter_powered || $past(converter_powered)) else $error("sampling while disabled");
   ctl_read_a: assert property ($past(reg_read) && $past(reg_addr) == 3'h0 |->
      reg_rdata[7] == $past(converter_powered) && reg_rdata[3] == 1'b0)
      else $error("control read wrong enable or spare bit");

   cover property ($rose(sample_hold));
   cover property (reg_read && reg_addr == 3'h4);
   cover property ($rose(converter_powered));
endmodule : acc_adc_conversion_control_chk

bind acc_adc_conversion_control acc_adc_conversion_control_chk #(
   .TRIGGER_COUNT(TRIGGER_COUNT), .BITS(BITS)) u_chk (
   .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .trigger_sources(trigger_sources), .comparator_high(comparator_high),
   .dac_code(dac_code), .sample_hold(sample_hold),
   .channel_select_bits(channel_select_bits),
   .reference_select_bits(reference_select_bits), .converter_powered(converter_powered));
`default_nettype wire

/* verif/acc_adc_conversion_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module acc_adc_conversion_control_tb;
   logic clk, reset, reg_write, reg_read, sample_hold, converter_powered;
   logic comparator_high = 1'b0;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [6:0] trigger_sources;
   logic [9:0] dac_code, vin, old;
   logic [4:0] channel_select_bits;
   logic [1:0] reference_select_bits;
   int bad_count, num_checks, cycles, n;

   acc_adc_conversion_control #(.TRIGGER_COUNT(7), .BITS(10)) u_dut (
      .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .trigger_sources(trigger_sources), .comparator_high(comparator_high),
      .dac_code(dac_code), .sample_hold(sample_hold),
      .channel_select_bits(channel_select_bits),
      .reference_select_bits(reference_select_bits), .converter_powered(converter_powered));

   // ---------------------------------------------------------------
   // clock, comparator model, timeout
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // one clock of lag is harmless: ticks come at most every second clock
   always @(posedge clk) comparator_high <= (dac_code <= vin);
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         bad_count++;
         summarize();
      end
   end

   // ---------------------------------------------------------------
   // bus tasks
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   // polls the flag; c counts clocks spent, so it bounds the wait too
   task automatic wait_flag(output int c);
      c = 0;
      do
      begin
         rd(3'h0, d);
         c += 2;
      end while (d[4] !== 1'b1 && c < 200);
   endtask : wait_flag
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial
   begin
      reset = 1'b1;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      trigger_sources = 7'h00;
      vin = 10'h2A5;
      bad_count = 0;
      num_checks = 0;
      cycles = 0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      for (int a = 0; a < 8; a++)
      begin
         rd(3'(a), d);
         check("reset value", d, 16'h0000);
      end
      wr(3'h5, 8'hFF);
      rd(3'h5, d);
      check("unmapped", d, 16'h0000);
      $display("test reset done");
      wr(3'h2, 8'hC5);
      tick(2);
      check("channel off", channel_select_bits, 16'h0000);
      rd(3'h2, d);
      check("input select", d, 16'h00C5);
      wr(3'h0, 8'h80);
      tick(2);
      check("channel on", channel_select_bits, 16'h0005);
      check("reference on", reference_select_bits, 16'h0003);
      check("powered", converter_powered, 16'h0001);
      wr(3'h0, 8'hC0);
      rd(3'h0, d);
      check("start high", d[6], 16'h0001);
      wait_flag(n);
      check("start cleared", d[6], 16'h0000);
      check("first length", 16'(n >= 48 && n <= 60), 16'h0001);
      rd(3'h3, d);
      check("low right", d, 16'(vin[7:0]));
      rd(3'h4, d);
      check("high right", d, 16'(vin[9:8]));
      wr(3'h0, 8'h90);
      rd(3'h0, d);
      check("flag cleared", d[4], 16'h0000);
      wr(3'h0, 8'hC0);
      wait_flag(n);
      check("normal length", 16'(n >= 24 && n <= 36), 16'h0001);
      wr(3'h0, 8'h90);
      $display("test single done");
      old = vin;
      vin = 10'h15A;
      wr(3'h2, 8'h25);
      rd(3'h3, d);
      check("low left", d, 16'({old[1:0], 6'h00}));
      wr(3'h0, 8'hC0);
      wait_flag(n);
      check("flag while locked", d[4], 16'h0001);
      rd(3'h4, d);
      check("high held", d, 16'(old[9:2]));
      wr(3'h0, 8'h90);
      wr(3'h0, 8'hC0);
      tick(6);
      wr(3'h2, 8'h29);
      tick(2);
      check("channel kept", channel_select_bits, 16'h0005);
      wait_flag(n);
      tick(2);
      check("channel moved", channel_select_bits, 16'h0009);
      rd(3'h3, d);
      check("low new", d, 16'({vin[1:0], 6'h00}));
      rd(3'h4, d);
      check("high new", d, 16'(vin[9:2]));
      wr(3'h0, 8'h90);
      $display("test lock done");
      wr(3'h1, 8'h01);
      wr(3'h0, 8'hA0);
      @(posedge clk) trigger_sources <= 7'h01;
      tick(4);
      rd(3'h0, d);
      check("trigger start", d[6], 16'h0001);
      @(posedge clk) trigger_sources <= 7'h00;
      @(posedge clk) trigger_sources <= 7'h01;
      wait_flag(n);
      tick(8);
      rd(3'h0, d);
      check("no retrigger", d[6], 16'h0000);
      wr(3'h0, 8'hB0);
      // source flag cleared before any further event
      @(posedge clk) trigger_sources <= 7'h00;
      // prescale 2: one tick every fourth clock
      wr(3'h0, 8'hE2);
      rd(3'h0, d);
      check("soft start auto", d[6], 16'h0001);
      wait_flag(n);
      check("soft auto length", 16'(n >= 50 && n <= 62), 16'h0001);
      wr(3'h0, 8'hB0);
      $display("test trigger done");
      wr(3'h1, 8'h00);
      wr(3'h0, 8'hE0);
      wait_flag(n);
      rd(3'h0, d);
      check("free run restart", d[6], 16'h0001);
      vin = 10'h3C3;
      tick(70);
      rd(3'h3, d);
      rd(3'h4, d);
      check("free run result", d, 16'(vin[9:2]));
      wr(3'h0, 8'h00);
      tick(2);
      check("powered off", converter_powered, 16'h0000);
      rd(3'h0, d);
      check("aborted", d[6], 16'h0000);
      $display("test free run done");
      summarize();
   end
endmodule : acc_adc_conversion_control_tb
`default_nettype wire
